// ---- verilog/prs_pkg.sv ----
// Constants, command and register-set types for the program-address unit.
// Assumes a 21-bit byte program space and 8-bit core registers.
package prs_pkg;

  // ****************************************************************
  // Widths and stack geometry
  // ****************************************************************
  localparam int PC_W        = 21;
  localparam int PTR_W       = 5;
  localparam int STACK_DEPTH = 31;
  localparam int INSTR_W     = 16;

  // ****************************************************************
  // Addresses, steps and vectors
  // ****************************************************************
  localparam logic [20:0] RESET_VECTOR = 21'h0_0000;
  localparam logic [20:0] VEC_HIGH     = 21'h0_0008;
  localparam logic [20:0] VEC_LOW      = 21'h0_0018;
  localparam logic [20:0] PC_STEP      = 21'h0_0002;

  localparam logic [4:0] PTR_EMPTY     = 5'h00;
  localparam logic [4:0] PTR_LAST_FREE = 5'h1E;
  localparam logic [4:0] PTR_MAX       = 5'h1F;
  localparam logic [4:0] PTR_ONE       = 5'h01;

  // ****************************************************************
  // Register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OFS_STACK_POINTER_STATUS = 8'h00;
  localparam logic [7:0] OFS_STACK_TOP_LOW_BYTE   = 8'h04;
  localparam logic [7:0] OFS_STACK_TOP_HIGH_BYTE  = 8'h08;
  localparam logic [7:0] OFS_STACK_TOP_UPPER_BYTE = 8'h0C;
  localparam logic [7:0] OFS_COUNTER_LOW_BYTE     = 8'h10;
  localparam logic [7:0] OFS_COUNTER_HIGH_LATCH   = 8'h14;
  localparam logic [7:0] OFS_COUNTER_UPPER_LATCH  = 8'h18;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT  = 6;

  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam logic [7:0] HIGH_LATCH_RESET  = 8'h00;
  localparam logic [4:0] UPPER_LATCH_RESET = 5'h00;
  localparam logic       OVR_EN_RESET      = 1'b1;

  // ****************************************************************
  // Core command port
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADVANCE,
    OP_JUMP,
    OP_CALL,
    OP_INTR_HI,
    OP_INTR_LO,
    OP_RETURN,
    OP_RETURN_FROM_INTERRUPT,
    OP_PUSH,
    OP_POP
  } prs_op_t;

  typedef struct packed {
    prs_op_t     op;
    logic        fast;
    logic [20:0] target;
  } prs_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } prs_regs_t;

endpackage

// ---- verilog/prs_stack_ram.sv ----
// Return-address storage: flip-flop entries 1..DEPTH, index 0 has none.
// Assumes one write port and one combinational read port on one clock.
`timescale 1ns/1ps

module prs_stack_ram #(
  parameter int DEPTH = 31,
  parameter int AW    = 5,
  parameter int DW    = 21
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [DW-1:0] rd_data
);

  if (DEPTH < 1 || DEPTH >= (1 << AW)) begin : g_bad_depth
    $error("prs_stack_ram: DEPTH must be 1 to 2**AW-1");
  end

  logic [DW-1:0] mem_q [1:DEPTH];

  // ****************************************************************
  // Storage
  // ****************************************************************
  // entry storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 1; i <= DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en && wr_idx != '0 && int'(wr_idx) <= DEPTH) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  always_comb begin
    rd_data = '0;
    if (rd_idx != '0 && int'(rd_idx) <= DEPTH) begin
      rd_data = mem_q[rd_idx];
    end
  end

endmodule

// ---- verilog/prs_pc_stack.sv ----
// Program counter, return stack control, fast shadow set and register slave.
// Assumes the core decoder issues one command per clock on hclk and a
// single AHB-Lite master drives word transfers.
`timescale 1ns/1ps

// Function
// - 21-bit counter; zeros above implemented memory
// - Reset at zero; vectors 0008h and 0018h
// - Low byte accessible; upper bits via latches
// - Low byte write loads latches into counter only when core op is OP_NONE
// - Low byte read copies counter into latches
// - Bit zero fixed; step two bytes
// - Jumps load counter directly, latches untouched
// - Calls, interrupts push; returns pop
// - 31 entries of 21 bits, private
// - Push increments first; pop reads then decrements
// - Reset clears pointer; zero means empty
// - Top bytes and pointer software accessible
// - Full after 31 pushes; software clears
// - Overflow reset stores address plus two
// - Without reset, pointer sticks at 31
// - Empty return loads zero; any empty pop flags underflow
// - Push stores counter; pop discards top
// - Status layout: full, underflow, zero, pointer
// - Interrupt captures shadows; fast return restores
// - Fast call saves; fast return restores
module prs_pc_stack #(
  parameter int MEM_BYTES = 65536
) (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            por_resetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic                                 hresp,
  output logic      [31:0]                     hrdata,
  input  wire prs_pkg::prs_cmd_t               core_cmd,
  input  wire prs_pkg::prs_regs_t              core_regs,
  output logic                                 restore_valid,
  output prs_pkg::prs_regs_t                   restore_regs,
  output logic      [prs_pkg::PC_W-1:0]        fetch_addr,
  input  wire logic [prs_pkg::INSTR_W-1:0]     mem_rdata,
  output logic      [prs_pkg::INSTR_W-1:0]     fetch_word,
  input  wire logic                            overflow_reset_enable,
  output logic                                 stack_reset_req
);

  if (MEM_BYTES < 2 || MEM_BYTES > (1 << prs_pkg::PC_W)) begin : g_bad_mem
    $error("prs_pc_stack: MEM_BYTES out of range");
  end

  localparam logic [21:0] MEM_LIMIT = 22'(MEM_BYTES);

  logic [20:0]        pc_q;
  logic [20:0]        pc_d;
  logic [7:0]         counter_high_latch_q;
  logic [4:0]         counter_upper_latch_q;
  logic [4:0]         ptr_q;
  logic [4:0]         ptr_d;
  logic               full_q;
  logic               unf_q;
  logic               ovr_meta_q;
  logic               ovr_en_q;
  logic               reset_req_q;
  logic [20:0]        tos_rd;
  logic               ram_we;
  logic [4:0]         ram_widx;
  logic [20:0]        ram_wdata;
  logic [20:0]        tos_merge;
  prs_pkg::prs_regs_t shadow_q;
  prs_pkg::prs_regs_t restore_regs_q;
  logic               restore_valid_q;
  logic [7:0]         addr_q;
  logic               wr_pend_q;
  logic               rd_pend_q;
  logic [31:0]        hrdata_q;
  logic [31:0]        rd_value;
  logic [15:0]        fetch_word_q;
  prs_pkg::prs_op_t   op;
  logic               is_push;
  logic               is_pop;
  logic               push_ovf;
  logic               push_blk;
  logic               pop_unf;
  logic               ovr_reset;
  logic               wr_status;
  logic               tos_wr;
  logic               pcl_wr;
  logic               pcl_rd_fx;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        addr_q    <= haddr[7:0];
        wr_pend_q <= hwrite;
        rd_pend_q <= !hwrite;
      end
    end
  end

  assign hreadyout = !rd_pend_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  assign wr_status = wr_pend_q && hit(addr_q, prs_pkg::OFS_STACK_POINTER_STATUS);
  assign pcl_wr    = wr_pend_q && hit(addr_q, prs_pkg::OFS_COUNTER_LOW_BYTE);
  assign pcl_rd_fx = rd_pend_q && hit(addr_q, prs_pkg::OFS_COUNTER_LOW_BYTE);
  assign tos_wr    = wr_pend_q && (hit(addr_q, prs_pkg::OFS_STACK_TOP_LOW_BYTE) ||
                                   hit(addr_q, prs_pkg::OFS_STACK_TOP_HIGH_BYTE) ||
                                   hit(addr_q, prs_pkg::OFS_STACK_TOP_UPPER_BYTE));

  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit(addr_q, prs_pkg::OFS_STACK_POINTER_STATUS)) begin
      rd_value[prs_pkg::FULL_BIT] = full_q;
      rd_value[prs_pkg::UNF_BIT]  = unf_q;
      rd_value[4:0]               = ptr_q;
    end else if (hit(addr_q, prs_pkg::OFS_STACK_TOP_LOW_BYTE)) begin
      rd_value[7:0] = tos_rd[7:0];
    end else if (hit(addr_q, prs_pkg::OFS_STACK_TOP_HIGH_BYTE)) begin
      rd_value[7:0] = tos_rd[15:8];
    end else if (hit(addr_q, prs_pkg::OFS_STACK_TOP_UPPER_BYTE)) begin
      rd_value[4:0] = tos_rd[20:16];
    end else if (hit(addr_q, prs_pkg::OFS_COUNTER_LOW_BYTE)) begin
      rd_value[7:0] = pc_q[7:0];
    end else if (hit(addr_q, prs_pkg::OFS_COUNTER_HIGH_LATCH)) begin
      rd_value[7:0] = counter_high_latch_q;
    end else if (hit(addr_q, prs_pkg::OFS_COUNTER_UPPER_LATCH)) begin
      rd_value[4:0] = counter_upper_latch_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_value;
    end
  end

  // ****************************************************************
  // Overflow-reset enable synchroniser
  // ****************************************************************
  // static enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_meta_q <= prs_pkg::OVR_EN_RESET;
      ovr_en_q   <= prs_pkg::OVR_EN_RESET;
    end else begin
      ovr_meta_q <= overflow_reset_enable;
      ovr_en_q   <= ovr_meta_q;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign op = core_cmd.op;

  assign is_push = (op == prs_pkg::OP_CALL) || (op == prs_pkg::OP_INTR_HI) ||
                   (op == prs_pkg::OP_INTR_LO) || (op == prs_pkg::OP_PUSH);
  assign is_pop  = (op == prs_pkg::OP_RETURN) || (op == prs_pkg::OP_RETURN_FROM_INTERRUPT) ||
                   (op == prs_pkg::OP_POP);

  assign push_ovf  = is_push && (ptr_q == prs_pkg::PTR_LAST_FREE);
  assign push_blk  = is_push && (ptr_q == prs_pkg::PTR_MAX);
  assign pop_unf   = is_pop && (ptr_q == prs_pkg::PTR_EMPTY);
  assign ovr_reset = ovr_en_q && (push_ovf || pop_unf);

  // ****************************************************************
  // Stack storage and write port
  // ****************************************************************
  // top byte merge
  always_comb begin
    tos_merge = tos_rd;
    if (hit(addr_q, prs_pkg::OFS_STACK_TOP_LOW_BYTE)) begin
      tos_merge[7:0] = hwdata[7:0];
    end else if (hit(addr_q, prs_pkg::OFS_STACK_TOP_HIGH_BYTE)) begin
      tos_merge[15:8] = hwdata[7:0];
    end else begin
      tos_merge[20:16] = hwdata[4:0];
    end
  end

  always_comb begin
    ram_we    = 1'b0;
    ram_widx  = 5'(ptr_q + prs_pkg::PTR_ONE);
    ram_wdata = pc_q;
    if (is_push) begin
      ram_we = !push_blk;
      if (push_ovf && ovr_en_q) begin
        ram_wdata = 21'(pc_q + prs_pkg::PC_STEP);
      end
    end else if (!is_pop && tos_wr && ptr_q != prs_pkg::PTR_EMPTY) begin
      ram_we    = 1'b1;
      ram_widx  = ptr_q;
      ram_wdata = tos_merge;
    end
  end

  prs_stack_ram #(
    .DEPTH (prs_pkg::STACK_DEPTH),
    .AW    (prs_pkg::PTR_W),
    .DW    (prs_pkg::PC_W)
  ) u_ram (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (ram_we),
    .wr_idx  (ram_widx),
    .wr_data (ram_wdata),
    .rd_idx  (ptr_q),
    .rd_data (tos_rd)
  );

  // ****************************************************************
  // Stack pointer
  // ****************************************************************
  // pointer movement
  always_comb begin
    ptr_d = ptr_q;
    if (is_push) begin
      if (!push_blk) begin
        ptr_d = 5'(ptr_q + prs_pkg::PTR_ONE);
      end
    end else if (is_pop) begin
      if (!pop_unf) begin
        ptr_d = 5'(ptr_q - prs_pkg::PTR_ONE);
      end
    end else if (wr_status) begin
      ptr_d = hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_q <= prs_pkg::PTR_EMPTY;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // ****************************************************************
  // Sticky flags: full and underflow cleared only by software or power-on, reset request only by hresetn
  // ****************************************************************
  // full flag
  always_ff @(posedge hclk or negedge por_resetn) begin
    if (!por_resetn) begin
      full_q <= prs_pkg::STATUS_RESET[prs_pkg::FULL_BIT];
      unf_q  <= prs_pkg::STATUS_RESET[prs_pkg::UNF_BIT];
    end else begin
      if (push_ovf || push_blk) begin
        full_q <= 1'b1;
      end else if (wr_status && !hwdata[prs_pkg::FULL_BIT]) begin
        full_q <= 1'b0;
      end
      if (pop_unf) begin
        unf_q <= 1'b1;
      end else if (wr_status && !hwdata[prs_pkg::UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_req_q <= 1'b0;
    end else if (ovr_reset) begin
      reset_req_q <= 1'b1;
    end
  end

  assign stack_reset_req = reset_req_q;

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // vectors
  always_comb begin
    case (op)
      prs_pkg::OP_ADVANCE: begin
        pc_d = 21'(pc_q + prs_pkg::PC_STEP);
      end
      prs_pkg::OP_JUMP, prs_pkg::OP_CALL: begin
        pc_d = {core_cmd.target[20:1], 1'b0};
      end
      prs_pkg::OP_INTR_HI: begin
        pc_d = prs_pkg::VEC_HIGH;
      end
      prs_pkg::OP_INTR_LO: begin
        pc_d = prs_pkg::VEC_LOW;
      end
      prs_pkg::OP_RETURN, prs_pkg::OP_RETURN_FROM_INTERRUPT: begin
        pc_d = pop_unf ? prs_pkg::RESET_VECTOR : {tos_rd[20:1], 1'b0};
      end
      default: begin
        pc_d = pc_q;
        if (pcl_wr && op == prs_pkg::OP_NONE) begin
          pc_d = {counter_upper_latch_q, counter_high_latch_q, hwdata[7:1], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= prs_pkg::RESET_VECTOR;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_high_latch_q  <= prs_pkg::HIGH_LATCH_RESET;
      counter_upper_latch_q <= prs_pkg::UPPER_LATCH_RESET;
    end else if (pcl_rd_fx) begin
      counter_high_latch_q  <= pc_q[15:8];
      counter_upper_latch_q <= pc_q[20:16];
    end else if (wr_pend_q && hit(addr_q, prs_pkg::OFS_COUNTER_HIGH_LATCH)) begin
      counter_high_latch_q <= hwdata[7:0];
    end else if (wr_pend_q && hit(addr_q, prs_pkg::OFS_COUNTER_UPPER_LATCH)) begin
      counter_upper_latch_q <= hwdata[4:0];
    end
  end

  // ****************************************************************
  // Fetch path
  // ****************************************************************
  // zeros above memory
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_word_q <= 16'h0000;
    end else begin
      fetch_word_q <= ({1'b0, pc_q} < MEM_LIMIT) ? mem_rdata : 16'h0000;
    end
  end

  assign fetch_addr = pc_q;
  assign fetch_word = fetch_word_q;

  // ****************************************************************
  // Fast shadow registers
  // ****************************************************************
  // interrupt capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_q        <= '0;
      restore_regs_q  <= '0;
      restore_valid_q <= 1'b0;
    end else begin
      restore_valid_q <= 1'b0;
      if (op == prs_pkg::OP_INTR_HI || op == prs_pkg::OP_INTR_LO ||
          (op == prs_pkg::OP_CALL && core_cmd.fast)) begin
        shadow_q <= core_regs;
      end
      if ((op == prs_pkg::OP_RETURN_FROM_INTERRUPT || op == prs_pkg::OP_RETURN) && core_cmd.fast) begin
        restore_regs_q  <= shadow_q;
        restore_valid_q <= 1'b1;
      end
    end
  end

  assign restore_valid = restore_valid_q;
  assign restore_regs  = restore_regs_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_pc_step: assert property (op == prs_pkg::OP_ADVANCE |=>
    pc_q == $past(pc_q) + prs_pkg::PC_STEP && pc_q[0] == 1'b0)
    else $error("counter did not step by two");

  chk_high_vector: assert property (op == prs_pkg::OP_INTR_HI && ptr_q < prs_pkg::PTR_LAST_FREE |=>
    pc_q == prs_pkg::VEC_HIGH && tos_rd == $past(pc_q))
    else $error("high interrupt vector or push wrong");

  chk_push_slot: assert property (is_push && ptr_q < prs_pkg::PTR_LAST_FREE |=>
    ptr_q == $past(ptr_q) + prs_pkg::PTR_ONE && tos_rd == $past(pc_q))
    else $error("push did not store at next slot");

  chk_full_sticky: assert property (push_ovf && !ovr_en_q |=>
    ptr_q == prs_pkg::PTR_MAX && full_q && !stack_reset_req)
    else $error("31st push without reset wrong");

  chk_full_hold: assert property (push_blk |=>
    ptr_q == prs_pkg::PTR_MAX && $stable(tos_rd))
    else $error("push beyond full moved or overwrote");

  chk_ovf_reset: assert property (push_ovf && ovr_en_q |=>
    stack_reset_req && full_q && tos_rd == $past(pc_q) + prs_pkg::PC_STEP)
    else $error("overflow reset sequence wrong");

  chk_unf_pop: assert property (pop_unf && op != prs_pkg::OP_POP |=>
    pc_q == prs_pkg::RESET_VECTOR && unf_q && ptr_q == prs_pkg::PTR_EMPTY)
    else $error("underflow pop wrong");

  chk_pcl_write: assert property (pcl_wr && op == prs_pkg::OP_NONE |=>
    (pc_q >> 8) == {$past(counter_upper_latch_q), $past(counter_high_latch_q)})
    else $error("low byte write did not load latches");

  chk_pcl_read: assert property (pcl_rd_fx |=>
    {counter_upper_latch_q, counter_high_latch_q} == ($past(pc_q) >> 8))
    else $error("low byte read did not fill latches");

  chk_jump_latch: assert property (op == prs_pkg::OP_JUMP |=>
    $stable(counter_high_latch_q) && $stable(counter_upper_latch_q) && !pc_q[0])
    else $error("jump disturbed latches");

  chk_shadow_back: assert property (op == prs_pkg::OP_RETURN_FROM_INTERRUPT && core_cmd.fast |=>
    restore_valid && restore_regs == $past(shadow_q))
    else $error("fast return did not restore shadows");

  chk_fetch_zero: assert property ({1'b0, pc_q} >= MEM_LIMIT |=>
    fetch_word == 16'h0000)
    else $error("fetch above memory not zero");

endmodule

// ---- bench/prs_core_model.sv ----
// Stand-in for the core decoder and program memory.
// Assumes requests change just after rising edges of hclk.
`timescale 1ns/1ps

module prs_core_model (
  input  wire prs_pkg::prs_op_t  req_op,
  input  wire logic [20:0]       req_target,
  input  wire logic              req_fast,
  input  wire logic              bus_busy,
  input  wire logic [20:0]       fetch_addr,
  output prs_pkg::prs_cmd_t      core_cmd,
  output logic      [15:0]       mem_rdata
);
  // ****************************************************************
  // Command and memory
  // ****************************************************************
  // interrupts masked on bus
  always_comb begin
    core_cmd.op     = req_op;
    core_cmd.fast   = req_fast;
    core_cmd.target = req_target;
    if (bus_busy && (req_op == prs_pkg::OP_INTR_HI || req_op == prs_pkg::OP_INTR_LO)) begin
      core_cmd.op = prs_pkg::OP_NONE;
    end
  end
  assign mem_rdata = fetch_addr[16:1] ^ 16'h5A5A;
endmodule

// ---- bench/prs_pc_stack_test.sv ----
// Self-checking bench for the program-address unit.
// Assumes prs_pkg, the design and the core model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end

module prs_pc_stack_test;
  logic               hclk = 0, hresetn = 0, por_resetn = 0, hwrite = 0, rq_fast = 0;
  logic               hreadyout, hresp, restore_valid, stack_reset_req, rd_ph = 0, ovr_en = 0;
  logic [1:0]         htrans = 2'h0;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [20:0]        rq_t = 21'h0, fetch_addr;
  logic [15:0]        mem_rdata, fetch_word;
  prs_pkg::prs_op_t   rq_op = prs_pkg::OP_NONE;
  prs_pkg::prs_cmd_t  core_cmd;
  prs_pkg::prs_regs_t core_regs = '0, restore_regs, sav;
  int                 error_cnt = 0, compares = 0, cyc = 0, seed = 4;
  logic [31:0]        q[$], exp_rd;
  prs_pkg::prs_op_t   ops[3] = '{prs_pkg::OP_INTR_HI, prs_pkg::OP_INTR_LO, prs_pkg::OP_CALL};
  logic [20:0]        vec[3] = '{21'h0_0008, 21'h0_0018, 21'h0_0040};

  always #5 hclk = ~hclk;

  prs_pc_stack #(.MEM_BYTES(4096)) DUT (.hclk(hclk), .hresetn(hresetn),
    .por_resetn(por_resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .core_cmd(core_cmd), .core_regs(core_regs),
    .restore_valid(restore_valid), .restore_regs(restore_regs), .fetch_addr(fetch_addr),
    .mem_rdata(mem_rdata), .fetch_word(fetch_word), .overflow_reset_enable(ovr_en),
    .stack_reset_req(stack_reset_req));

  prs_core_model core (.req_op(rq_op), .req_target(rq_t), .req_fast(rq_fast),
    .bus_busy(htrans[1]), .fetch_addr(fetch_addr), .core_cmd(core_cmd),
    .mem_rdata(mem_rdata));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim;
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    if (!w) q.push_back(d);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
  endtask

  task automatic op(input prs_pkg::prs_op_t o, input logic [20:0] t, input logic f,
                    input prs_pkg::prs_regs_t rg);
    @(posedge hclk);
    rq_op <= o;
    rq_t <= t;
    rq_fast <= f;
    core_regs <= rg;
  endtask

  task automatic run(input prs_pkg::prs_op_t o, input logic [20:0] t, input logic f);
    op(o, t, f, core_regs);
    op(prs_pkg::OP_NONE, 21'h0, 1'b0, core_regs);
    #1;
  endtask

  // ****************************************************************
  // Read monitor and timeout
  // ****************************************************************
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      exp_rd = q.pop_front();
      `CHK(hrdata, exp_rd)
      `CHK(hresp, 1'b0)
    end
    rd_ph <= (htrans[1] && !hwrite && hreadyout) || (rd_ph && !hreadyout);
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      end_sim;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    por_resetn <= 1'b1;
    run(prs_pkg::OP_ADVANCE, 21'h0, 1'b0);
    run(prs_pkg::OP_ADVANCE, 21'h0, 1'b0);
    `CHK(fetch_addr, 21'h0_0004)
    run(prs_pkg::OP_CALL, 21'h1_2345, 1'b0);
    `CHK(fetch_addr, 21'h1_2344)
    bus(0, 8'h00, 32'h0000_0001);
    bus(0, 8'h04, 32'h0000_0004);
    bus(0, 8'h0C, 32'h0000_0000);
    bus(0, 8'h10, 32'h0000_0044);
    bus(0, 8'h14, 32'h0000_0023);
    bus(0, 8'h18, 32'h0000_0001);
    bus(0, 8'h1C, 32'h0000_0000);
    bus(1, 8'h04, 32'h0000_0006);
    bus(0, 8'h04, 32'h0000_0006);
    bus(1, 8'h14, 32'h0000_0056);
    bus(1, 8'h18, 32'h0000_0007);
    bus(1, 8'h10, 32'h0000_009B);
    #1;
    `CHK(fetch_addr, 21'h7_569A)
    @(posedge hclk);
    #1;
    `CHK(fetch_word, 16'h0000)
    run(prs_pkg::OP_RETURN, 21'h0, 1'b0);
    `CHK(fetch_addr, 21'h0_0006)
    @(posedge hclk);
    #1;
    `CHK(fetch_word, 16'h5A59)
    for (int i = 0; i < 3; i++) begin
      sav = 24'($random(seed));
      run(prs_pkg::OP_JUMP, 21'h0_0100, 1'b0);
      op(ops[i], 21'h0_0041, 1'b1, sav);
      run(prs_pkg::OP_NONE, 21'h0, 1'b0);
      `CHK(fetch_addr, vec[i])
      op(i < 2 ? prs_pkg::OP_RETURN_FROM_INTERRUPT : prs_pkg::OP_RETURN, 21'h0, 1'b1, ~sav);
      op(prs_pkg::OP_NONE, 21'h0, 1'b0, core_regs);
      #1;
      `CHK(fetch_addr, 21'h0_0100)
      `CHK(restore_valid, 1'b1)
      `CHK(restore_regs, sav)
    end
    repeat (32) op(prs_pkg::OP_PUSH, 21'h0, 1'b0, core_regs);
    run(prs_pkg::OP_NONE, 21'h0, 1'b0);
    bus(0, 8'h00, 32'h0000_009F);
    run(prs_pkg::OP_POP, 21'h0, 1'b0);
    bus(0, 8'h00, 32'h0000_009E);
    bus(1, 8'h00, 32'h0000_0000);
    bus(0, 8'h00, 32'h0000_0000);
    run(prs_pkg::OP_RETURN, 21'h0, 1'b0);
    `CHK(fetch_addr, 21'h0_0000)
    `CHK(stack_reset_req, 1'b0)
    bus(0, 8'h00, 32'h0000_0040);
    bus(1, 8'h00, 32'h0000_00FF);
    bus(0, 8'h00, 32'h0000_005F);
    bus(1, 8'h00, 32'h0000_001E);
    @(posedge hclk);
    ovr_en <= 1'b1;
    repeat (3) @(posedge hclk);
    run(prs_pkg::OP_JUMP, 21'h0_0200, 1'b0);
    run(prs_pkg::OP_PUSH, 21'h0, 1'b0);
    `CHK(stack_reset_req, 1'b1)
    bus(0, 8'h04, 32'h0000_0002);
    bus(0, 8'h08, 32'h0000_0002);
    bus(0, 8'h00, 32'h0000_009F);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 8'h00, 32'h0000_0080);
    #1;
    `CHK(fetch_addr, 21'h0_0000)
    run(prs_pkg::OP_RETURN, 21'h0, 1'b0);
    `CHK(stack_reset_req, 1'b1)
    end_sim;
  end
endmodule
